// >>> core/indexed_port_watchdog_timer.sv
// watchdog timer behind an index/data host port pair
`timescale 1ns/1ps
`include "wdt_cfg.svh"
module indexed_port_watchdog_timer #(
  parameter int unsigned CYCLES_PER_SEC = `CLK_HZ,
  parameter int unsigned RST_PULSE_CYCLES = `RST_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire wdt_pkg::io_req_t io_req,
  output wdt_pkg::io_rsp_t io_rsp,
  input wire logic timeout_route_jumper,
  input wire logic kbd_activity,
  output logic irq11_b,
  output logic sys_reset_b
);
  import wdt_pkg::*;

  // ---------------- pin synchronisers ----------------
  logic [2:0] jmp_sync_reg;
  logic [2:0] kbd_sync_reg;
  logic jmp_reg;
  logic kbd_reg;
  logic kbd_prev_reg;
  logic jmp_agree;
  logic kbd_agree;
  logic kbd_edge;

  // a change only counts once stages two and three agree
  assign jmp_agree = (jmp_sync_reg[1] == jmp_sync_reg[2]);
  assign kbd_agree = (kbd_sync_reg[1] == kbd_sync_reg[2]);
  assign kbd_edge = kbd_reg && !kbd_prev_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      jmp_sync_reg <= 3'h0;
      kbd_sync_reg <= 3'h0;
    end else begin
      jmp_sync_reg <= {jmp_sync_reg[1:0], timeout_route_jumper};
      kbd_sync_reg <= {kbd_sync_reg[1:0], kbd_activity};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      jmp_reg <= 1'b0;
      kbd_reg <= 1'b0;
      kbd_prev_reg <= 1'b0;
    end else begin
      if (jmp_agree) begin
        jmp_reg <= jmp_sync_reg[2];
      end
      if (kbd_agree) begin
        kbd_reg <= kbd_sync_reg[2];
      end
      kbd_prev_reg <= kbd_reg;
    end
  end

  // ---------------- port decode ----------------
  logic idx_hit;
  logic data_hit;
  logic idx_wr;
  logic data_wr;
  logic data_rd;

  assign idx_hit = (io_req.addr == `IDX_PORT_ADDR);
  assign data_hit = (io_req.addr == `DATA_PORT_ADDR);
  assign idx_wr = io_req.wr && idx_hit;
  assign data_wr = io_req.wr && data_hit;
  assign data_rd = io_req.rd && data_hit;

  // ---------------- key sequence ----------------
  cfg_state_t cfg_reg;
  cfg_state_t cfg_next;
  logic is_unlock_key;
  logic is_lock_key;
  logic cfg_open;

  assign is_unlock_key = (io_req.wdata == `KEY_UNLOCK);
  assign is_lock_key = (io_req.wdata == `KEY_LOCK);
  assign cfg_open = (cfg_reg == CFG_OPEN);

  always_comb begin
    cfg_next = cfg_reg;
    if (idx_wr) begin
      case (cfg_reg)
        CFG_LOCKED: begin
          cfg_next = is_unlock_key ? CFG_HALF_KEY : CFG_LOCKED;
        end
        CFG_HALF_KEY: begin
          cfg_next = is_unlock_key ? CFG_OPEN : CFG_LOCKED;
        end
        CFG_OPEN: begin
          cfg_next = is_lock_key ? CFG_LOCKED : CFG_OPEN;
        end
        default: begin
          cfg_next = CFG_LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_reg <= CFG_LOCKED;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // ---------------- configuration registers ----------------
  logic [7:0] index_reg;
  logic [7:0] block_sel_reg;
  logic func_en_reg;
  logic unit_min_reg;
  logic [7:0] count_load_reg;
  logic kbd_en_reg;
  logic wd_mapped;
  logic wd_wr;
  logic wr_block_sel;
  logic wr_func_en;
  logic wr_unit;
  logic wr_count;
  logic wr_ctrl;
  logic force_timeout;

  // index is taken from the last index write while open, other than the lock key
  // watchdog set is visible only when block 08 is selected
  assign wd_mapped = (block_sel_reg == `BLOCK_WATCHDOG);
  // locked writes fall on the floor
  assign wd_wr = data_wr && cfg_open && wd_mapped;
  assign wr_block_sel = data_wr && cfg_open && (index_reg == `IDX_BLOCK_SEL);
  assign wr_func_en = wd_wr && (index_reg == `IDX_FUNC_EN);
  assign wr_unit = wd_wr && (index_reg == `IDX_UNIT_SEL);
  assign wr_count = wd_wr && (index_reg == `IDX_COUNT);
  assign wr_ctrl = wd_wr && (index_reg == `IDX_CTRL_STAT);
  // force bit is a write-only strobe, never stored
  assign force_timeout = wr_ctrl && io_req.wdata[`FORCE_BIT];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      index_reg <= `RST_BYTE;
    end else if (idx_wr && cfg_open && !is_lock_key) begin
      index_reg <= io_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      block_sel_reg <= `RST_BYTE;
    end else if (wr_block_sel) begin
      block_sel_reg <= io_req.wdata;
    end
  end

  // enabled only by the exact value 01
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      func_en_reg <= 1'b0;
    end else if (wr_func_en) begin
      func_en_reg <= (io_req.wdata == `FUNC_EN_VALUE);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      unit_min_reg <= 1'b0;
    end else if (wr_unit) begin
      unit_min_reg <= io_req.wdata[`UNIT_MINUTE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_load_reg <= `RST_BYTE;
    end else if (wr_count) begin
      count_load_reg <= io_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      kbd_en_reg <= 1'b0;
    end else if (wr_ctrl) begin
      kbd_en_reg <= io_req.wdata[`KBD_EN_BIT];
    end
  end

  // ---------------- time base ----------------
  logic sec_tick;
  logic restart;
  logic [5:0] sec_in_min_reg;
  logic min_tick;
  logic unit_tick;

  // count write restarts; keyboard restarts when allowed
  assign restart = wr_count || (kbd_edge && kbd_en_reg);

  // the divider restarts too, so a fresh count gets full units
  tick_divider #(
    .CYCLES(CYCLES_PER_SEC)
  ) tick_divider_i (
    .clk(clk),
    .rst_b(rst_b),
    .clear(restart),
    .tick(sec_tick)
  );

  assign min_tick = sec_tick && (sec_in_min_reg == (`SEC_PER_MIN - 6'd1));
  // unit is one second or one minute
  assign unit_tick = unit_min_reg ? min_tick : sec_tick;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sec_in_min_reg <= 6'h00;
    end else if (restart || min_tick) begin
      sec_in_min_reg <= 6'h00;
    end else if (sec_tick) begin
      sec_in_min_reg <= sec_in_min_reg + 6'h01;
    end
  end

  // ---------------- countdown ----------------
  logic [7:0] remain_reg;
  logic [7:0] remain_next;
  logic running;
  logic expire;
  logic timed_out_reg;
  logic timed_out_next;

  // zero in the count register stops the timer
  assign running = func_en_reg && (remain_reg != 8'h00);
  assign expire = running && unit_tick && (remain_reg == 8'h01);

  always_comb begin
    remain_next = remain_reg;
    if (restart) begin
      // reload from the value just written, or from the stored count on a keyboard restart
      remain_next = wr_count ? io_req.wdata : count_load_reg;
    end else if (running && unit_tick) begin
      remain_next = remain_reg - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      remain_reg <= 8'h00;
    end else begin
      remain_reg <= remain_next;
    end
  end

  // set wins over the clear from a restart in the same cycle
  // expired or forced timeout; held until restart
  assign timed_out_next = (func_en_reg && (expire || force_timeout)) ? 1'b1 :
                          restart ? 1'b0 : timed_out_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timed_out_reg <= 1'b0;
    end else begin
      timed_out_reg <= timed_out_next;
    end
  end

  // ---------------- outputs ----------------
  logic new_timeout;
  logic [15:0] rst_cnt_reg;
  logic rst_active;

  assign new_timeout = timed_out_next && !timed_out_reg;
  assign rst_active = (rst_cnt_reg != 16'h0000);

  // reset route gives a fixed pulse; holding it would keep the board in reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_cnt_reg <= 16'h0000;
    end else if (new_timeout && jmp_reg) begin
      rst_cnt_reg <= 16'(RST_PULSE_CYCLES);
    end else if (rst_active) begin
      rst_cnt_reg <= rst_cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq11_b <= 1'b1;
      sys_reset_b <= 1'b1;
    end else begin
      irq11_b <= !(timed_out_next && !jmp_reg);
      sys_reset_b <= !((new_timeout && jmp_reg) || (rst_cnt_reg > 16'h0001));
    end
  end

  // ---------------- read path ----------------
  logic [7:0] ctrl_rd;
  logic [7:0] rd_mux;

  // status bit shows timeout; force bit reads zero
  assign ctrl_rd = {1'b0, kbd_en_reg, 1'b0, timed_out_reg, 4'h0};

  always_comb begin
    rd_mux = 8'h00;
    if (idx_hit) begin
      rd_mux = index_reg;
    end else if (cfg_open && index_reg == `IDX_BLOCK_SEL) begin
      rd_mux = block_sel_reg;
    end else if (cfg_open && wd_mapped) begin
      case (index_reg)
        `IDX_FUNC_EN: rd_mux = {7'h00, func_en_reg};
        `IDX_UNIT_SEL: rd_mux = {4'h0, unit_min_reg, 3'h0};
        `IDX_COUNT: rd_mux = count_load_reg;
        `IDX_CTRL_STAT: rd_mux = ctrl_rd;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_rsp <= '0;
    end else begin
      io_rsp.valid <= io_req.rd && (idx_hit || data_hit);
      io_rsp.data <= (io_req.rd && (idx_hit || data_rd)) ? rd_mux : 8'h00;
    end
  end

endmodule

// >>> core/tick_divider.sv
// one-cycle enable pulse every CYCLES clocks, restartable
`timescale 1ns/1ps
module tick_divider #(
  parameter int unsigned CYCLES = 10000000
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clear,
  output logic tick
);

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic at_end;

  assign at_end = (cnt_reg == 32'(CYCLES - 1));
  assign cnt_next = (clear || at_end) ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick <= at_end && !clear;
    end
  end

endmodule

// >>> core/wdt_cfg.svh
// constants for the indexed-port watchdog timer
// How it works
// - watchdog runs only after 01 is written to index 30; disabled after reset
// - timeout programmable from 1 to 255 units of a second or a minute
// - count expiring without restart raises the timeout as interrupt or reset
// - a static board jumper routes the timeout to system reset or interrupt 11
// - interrupt form is active low and held until the timer restarts
// - two host ports: index port selects a register, data port accesses it
// - writing key 87 twice to the index port unlocks configuration
// - writing 08 to index 07 maps the watchdog registers
// - index F5 bit 3 selects unit: 0 seconds (default), 1 minutes
// - index F6 zero stops the timer (default); 01 to FF sets tick count
// - each write of the count register restarts from the new value
// - index F7 bit 6 lets keyboard activity restart the count; cleared at reset
// - writing 1 to F7 bit 5 forces a timeout while index 30 holds 01, and the bit self-clears
// - F7 bit 4 reads 1 once the watchdog has timed out
// - writing key AA to the index port locks configuration again
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

`define IDX_PORT_ADDR 16'h002E
`define DATA_PORT_ADDR 16'h002F

`define KEY_UNLOCK 8'h87
`define KEY_LOCK 8'hAA

`define IDX_BLOCK_SEL 8'h07
`define IDX_FUNC_EN 8'h30
`define IDX_UNIT_SEL 8'hF5
`define IDX_COUNT 8'hF6
`define IDX_CTRL_STAT 8'hF7

`define BLOCK_WATCHDOG 8'h08
`define FUNC_EN_VALUE 8'h01

`define UNIT_MINUTE_BIT 3
`define KBD_EN_BIT 6
`define FORCE_BIT 5
`define STATUS_BIT 4

`define RST_BYTE 8'h00

// one second at the 10 MHz clock
`define CLK_HZ 10000000
`define SEC_PER_MIN 6'd60
// reset pulse width in ns, rounded up to whole cycles
`define RST_PULSE_NS 1000
`define CLK_PERIOD_NS 100
`define RST_PULSE_CYC ((`RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> core/wdt_pkg.sv
// types shared by the watchdog files
package wdt_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } io_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } io_rsp_t;

  typedef enum logic [1:0] {
    CFG_LOCKED,
    CFG_HALF_KEY,
    CFG_OPEN
  } cfg_state_t;

endpackage

// >>> verif/host_model.sv
// host processor issuing index and data port cycles
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  input wire wdt_pkg::io_rsp_t io_rsp,
  output wdt_pkg::io_req_t io_req
);
  import wdt_pkg::*;
  initial io_req = '0;
  // one strobe cycle; released lines show the inverse so stale values never match
  task automatic cyc(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    io_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk);
    q = io_rsp.data;
    io_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] val);
    logic [7:0] q;
    cyc(1'b1, 16'h002E, idx, q);
    cyc(1'b1, 16'h002F, val, q);
  endtask
  task automatic reg_rd(input logic [7:0] idx, output logic [7:0] q);
    cyc(1'b1, 16'h002E, idx, q);
    cyc(1'b0, 16'h002F, 8'h00, q);
  endtask
  task automatic unlock();
    logic [7:0] q;
    cyc(1'b1, 16'h002E, 8'h87, q);
    cyc(1'b1, 16'h002E, 8'h87, q);
  endtask
  task automatic lock();
    logic [7:0] q;
    cyc(1'b1, 16'h002E, 8'hAA, q);
  endtask
endmodule

// >>> verif/indexed_port_watchdog_timer_bench.sv
// self-checking bench for the indexed-port watchdog
`timescale 1ns/1ps
module indexed_port_watchdog_timer_bench;
  import wdt_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic jumper = 1'b0;
  logic kbd = 1'b0;
  io_req_t io_req;
  io_rsp_t io_rsp;
  logic irq11_b;
  logic sys_reset_b;
  logic [7:0] q;
  int n_errors = 0;
  int checked = 0;

  // 20 cycles to the second keeps minute tests short
  indexed_port_watchdog_timer #(.CYCLES_PER_SEC(20), .RST_PULSE_CYCLES(4)) indexed_port_watchdog_timer_i (
    .clk(clk), .rst_b(rst_b), .io_req(io_req), .io_rsp(io_rsp), .timeout_route_jumper(jumper),
    .kbd_activity(kbd), .irq11_b(irq11_b), .sys_reset_b(sys_reset_b));
  host_model host_model_i (.clk(clk), .io_rsp(io_rsp), .io_req(io_req));

  initial forever #50 clk = ~clk;

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    host_model_i.reg_rd(idx, v);
    chk(what, v, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end

  initial begin
    idle(20);
    rst_b = 1'b1;
    host_model_i.cyc(1'b0, 16'h002F, 8'h00, q);
    chk("locked data", q, 8'h00);
    host_model_i.cyc(1'b1, 16'h002E, 8'h87, q);
    host_model_i.cyc(1'b1, 16'h002E, 8'h07, q);
    host_model_i.cyc(1'b0, 16'h002E, 8'h00, q);
    chk("half key index", q, 8'h00);
    host_model_i.unlock();
    rd_chk("select reset", 8'h07, 8'h00);
    host_model_i.reg_wr(8'h30, 8'h01);
    host_model_i.reg_wr(8'h07, 8'h08);
    rd_chk("select", 8'h07, 8'h08);
    rd_chk("enable unmapped", 8'h30, 8'h00);
    host_model_i.cyc(1'b0, 16'h002E, 8'h00, q);
    chk("index port", q, 8'h30);
    $display("test access done");
    host_model_i.reg_wr(8'hF6, 8'h02);
    idle(60);
    rd_chk("disabled status", 8'hF7, 8'h00);
    host_model_i.reg_wr(8'h30, 8'h01);
    rd_chk("enable", 8'h30, 8'h01);
    host_model_i.reg_wr(8'hF6, 8'h02);
    idle(28);
    rd_chk("before expiry", 8'hF7, 8'h00);
    idle(12);
    rd_chk("expired", 8'hF7, 8'h10);
    chk("irq low", {7'h00, irq11_b}, 8'h00);
    host_model_i.lock();
    host_model_i.reg_wr(8'hF6, 8'h00);
    idle(20);
    chk("irq held", {7'h00, irq11_b}, 8'h00);
    host_model_i.unlock();
    host_model_i.reg_wr(8'hF6, 8'h00);
    idle(3);
    chk("irq restart", {7'h00, irq11_b}, 8'h01);
    idle(60);
    rd_chk("stopped", 8'hF7, 8'h00);
    $display("test seconds done");
    host_model_i.reg_wr(8'hF6, 8'hFF);
    idle(20 * 255 - 12);
    rd_chk("max count early", 8'hF7, 8'h00);
    idle(12);
    rd_chk("max count late", 8'hF7, 8'h10);
    host_model_i.reg_wr(8'hF5, 8'h08);
    rd_chk("minute unit", 8'hF5, 8'h08);
    host_model_i.reg_wr(8'hF6, 8'h01);
    idle(1188);
    rd_chk("minute early", 8'hF7, 8'h00);
    idle(12);
    rd_chk("minute late", 8'hF7, 8'h10);
    host_model_i.reg_wr(8'hF5, 8'h00);
    $display("test counts done");
    for (int k = 1; k >= 0; k--) begin
      host_model_i.reg_wr(8'hF7, k ? 8'h40 : 8'h00);
      host_model_i.reg_wr(8'hF6, 8'h01);
      repeat (6) begin
        idle(8);
        kbd = ~kbd;
      end
      rd_chk("keyboard restart", 8'hF7, k ? 8'h40 : 8'h10);
    end
    $display("test keyboard done");
    // the jumper is static on a board, so it only moves while no timeout is pending
    host_model_i.reg_wr(8'hF6, 8'h00);
    jumper = 1'b1;
    idle(5);
    host_model_i.reg_wr(8'hF7, 8'h20);
    idle(2);
    chk("reset route", {7'h00, sys_reset_b}, 8'h00);
    chk("irq idle", {7'h00, irq11_b}, 8'h01);
    rd_chk("force self clear", 8'hF7, 8'h10);
    host_model_i.reg_wr(8'hF6, 8'h00);
    jumper = 1'b0;
    $display("test force done");
    summarize();
  end
endmodule

bind indexed_port_watchdog_timer wdt_monitor #(.RST_PULSE_CYCLES(RST_PULSE_CYCLES)) wdt_monitor_i (
  .clk(clk), .rst_b(rst_b), .io_req(io_req), .io_rsp(io_rsp), .timeout_route_jumper(timeout_route_jumper),
  .kbd_activity(kbd_activity), .irq11_b(irq11_b), .sys_reset_b(sys_reset_b));

// >>> verif/wdt_monitor.sv
// port assertions for the watchdog
`timescale 1ns/1ps
module wdt_monitor #(
  parameter int unsigned RST_PULSE_CYCLES = 10
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire wdt_pkg::io_req_t io_req,
  input wire wdt_pkg::io_rsp_t io_rsp,
  input wire logic timeout_route_jumper,
  input wire logic kbd_activity,
  input wire logic irq11_b,
  input wire logic sys_reset_b
);
  import wdt_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [7:0] low_cnt;
  // length of the current reset pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) low_cnt <= 8'h00;
    else low_cnt <= sys_reset_b ? 8'h00 : low_cnt + 8'h01;
  end
  sequence port_read;
    io_req.rd && io_req.addr[15:1] == 15'h0017;
  endsequence
  a_read_answer_next: assert property (port_read |=> io_rsp.valid)
    else $error("no answer one cycle after a port read");
  a_answer_has_cause: assert property (io_rsp.valid |-> $past(io_req.rd))
    else $error("answer without a read");
  a_idle_data_zero: assert property (!io_rsp.valid |-> io_rsp.data == 8'h00)
    else $error("data driven outside an answer");
  // a restart needs a host write or a keyboard edge
  a_irq_held_low: assert property ($fell(irq11_b) && !io_req.wr && !kbd_activity |=> !irq11_b)
    else $error("interrupt released without restart");
  a_reset_width: assert property ($rose(sys_reset_b) |-> low_cnt == 8'(RST_PULSE_CYCLES))
    else $error("reset pulse of wrong width");
  a_routes_exclusive: assert property (!(!irq11_b && !sys_reset_b))
    else $error("both timeout routes active");
  a_irq_route: assert property (!irq11_b |-> !timeout_route_jumper)
    else $error("interrupt on the reset route");
  a_reset_route: assert property ($fell(sys_reset_b) |-> timeout_route_jumper)
    else $error("reset on the interrupt route");
endmodule
